/* rtl/smx_params.svh */
// Constants for the static memory expansion port sequencer.
`ifndef SMX_PARAMS_SVH
`define SMX_PARAMS_SVH
`define SMX_ADDR_W 28
`define SMX_DATA_W 32
`define SMX_NCS 6
`define SMX_WS_W 3
`define SMX_BURST_MIN 3'h2
`define SMX_BURST_MAX 3'h4
`define SMX_RD_FIRST_MIN_WS 3'h1
`define SMX_WR_MIN_WS 3'h1
`define SMX_REG_CTRL 12'h000
`define SMX_REG_ADDR 12'h004
`define SMX_REG_WDATA 12'h008
`define SMX_REG_RDATA 12'h00c
`define SMX_REG_STAT 12'h010
`define SMX_CTRL_RST 32'h0000_0000
`endif

/* rtl/smx_pkg.sv */
// Types for the static memory expansion port sequencer.
package smx_pkg;
  typedef enum logic [2:0] {
    SMX_IDLE = 3'b000,
    SMX_SETUP = 3'b001,
    SMX_WAIT = 3'b011,
    SMX_STROBE = 3'b010,
    SMX_DONE = 3'b110
  } smx_state_e;
endpackage

/* rtl/smx_sync.sv */
// Two-stage synchroniser for a pin level.
`timescale 1ns/1ns
module smx_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

/* rtl/smx_port.sv */
// Static memory and expansion bus sequencer with an APB register port.
// Functional notes
// - Accesses lengthen in whole bus clock periods: wait states plus ready stalls.
// - Ready sampled at falling edge before transfer; low adds one period.
// - Reads keep address, width qualifiers and direction until next cycle.
// - Writes also keep write data steady until the next cycle.
// - Zero sequential write wait states are refused for strobe-written memories.
// - Bursts are two to four beats; four is the most.
// - Minimum burst read uses waits one, zero, zero, zero.
// - Minimum burst write uses one wait on every beat.
// - Sequential mode uses the sequential wait field, no idle between beats.
// - Software should set sequential access whenever the memory allows.
// - Chip select asserts after rising edge, releases after falling edge.
// - A new address launches from a rising bus clock edge.
// - Write strobe asserts and releases on rising edges.
// - Output strobe asserts and releases on falling edges.
// - Write data is driven from a rising bus clock edge.
// - Direction from a rising edge, full-width qualifier from a falling edge.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ns
`include "smx_params.svh"
module smx_port
  import smx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_clock,
  input wire logic ext_ready_in,
  output logic [`SMX_NCS-1:0] chip_sel_n,
  output logic [`SMX_ADDR_W-1:0] mem_addr,
  output logic mem_write_strobe_n,
  output logic mem_output_strobe_n,
  output logic mem_write_dir,
  output logic mem_word,
  output logic mem_halfword,
  output logic [`SMX_DATA_W-1:0] mem_wdata,
  output logic mem_wdata_oe,
  input wire logic [`SMX_DATA_W-1:0] mem_rdata
);
  // Control: [0] start (self-clearing), [1] write, [2] seq_access_enable,
  // [3] strobe-written memory, [6:4] wait states, [9:7] sequential wait
  // states, [12:10] burst beats, [15:13] chip select, [17:16] width
  // (0 byte, 1 half, 2 word).
  logic [31:0] ctrl_q, ctrl_d;
  logic [`SMX_ADDR_W-1:0] addr_q, addr_d;
  logic [31:0] wdat_q, wdat_d, rdat_q, rdat_d;
  logic busy_q, busy_d, err_q, err_d;
  logic [31:0] prdata_q, prdata_d;

  logic clk_s, rdy_s, clk_prev_q;
  logic rise, fall;
  smx_sync u_sync_clk (.pclk(pclk), .presetn(presetn), .async_in(bus_clock), .sync_out(clk_s));
  // The ready pin needs no alignment to the bus clock by the memory.
  smx_sync u_sync_rdy (.pclk(pclk), .presetn(presetn), .async_in(ext_ready_in),
    .sync_out(rdy_s));

  // Read data is captured well after the memory has settled, so a per-bit
  // synchroniser costs no bus clock periods.
  logic [`SMX_DATA_W-1:0] rdata_s;
  for (genvar i = 0; i < `SMX_DATA_W; i++) begin : g_rd_sync
    smx_sync u_sync_rd (.pclk(pclk), .presetn(presetn), .async_in(mem_rdata[i]),
      .sync_out(rdata_s[i]));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_s;
    end
  end
  assign rise = clk_s & ~clk_prev_q;
  assign fall = ~clk_s & clk_prev_q;

  smx_state_e st_q, st_d;
  logic [2:0] cnt_q, cnt_d, beat_q, beat_d;
  logic [`SMX_NCS-1:0] cs_q, cs_d;
  logic [`SMX_ADDR_W-1:0] ma_q, ma_d;
  logic mwe_q, mwe_d, moe_q, moe_d, dir_q, dir_d, wd_q, wd_d, hw_q, hw_d;
  logic [`SMX_DATA_W-1:0] md_q, md_d;
  logic oe_q, oe_d, last_beat;

  wire apb_wr = psel & penable & pwrite;
  wire apb_rd = psel & ~penable & ~pwrite;
  wire start_ok = !(pwdata[1] & pwdata[3] & pwdata[2] & (pwdata[9:7] == 3'h0));
  wire [2:0] ws = ctrl_q[6:4];
  wire [2:0] seq_ws = ctrl_q[9:7];
  // Sequential access saves wait states; software should set it where it can.
  wire seq_access_enable = ctrl_q[2];
  wire [2:0] beats_raw = ctrl_q[12:10];
  // Beats below two give a single access and beats above four are clamped to four, rather than refused.
  wire [2:0] beats = (beats_raw < `SMX_BURST_MIN) ? 3'h1 :
    (beats_raw > `SMX_BURST_MAX) ? `SMX_BURST_MAX : beats_raw;
  wire bad_cfg = ctrl_q[1] & ctrl_q[3] & seq_access_enable & (seq_ws == 3'h0);

  function automatic logic [2:0] beat_ws(input logic [2:0] b);
    logic [2:0] w;
    w = (b != 3'h0 && seq_access_enable) ? seq_ws : ws;
    if (ctrl_q[1] && w < `SMX_WR_MIN_WS) w = `SMX_WR_MIN_WS;
    if (!ctrl_q[1] && b == 3'h0 && w < `SMX_RD_FIRST_MIN_WS) w = `SMX_RD_FIRST_MIN_WS;
    return w;
  endfunction

  assign last_beat = (beat_q + 3'h1 >= beats);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    beat_d = beat_q;
    cs_d = cs_q;
    ma_d = ma_q;
    mwe_d = mwe_q;
    moe_d = moe_q;
    dir_d = dir_q;
    wd_d = wd_q;
    hw_d = hw_q;
    md_d = md_q;
    oe_d = oe_q;
    rdat_d = rdat_q;
    busy_d = busy_q;
    case (st_q)
      SMX_IDLE: begin
        if (busy_q && rise) begin
          // Address, direction, data and select all launch on a rising edge.
          cs_d = ~(`SMX_NCS'(1) << ctrl_q[15:13]);
          ma_d = addr_q;
          dir_d = ctrl_q[1];
          hw_d = (ctrl_q[17:16] == 2'h1);
          md_d = wdat_q;
          oe_d = ctrl_q[1];
          mwe_d = ~ctrl_q[1];
          cnt_d = beat_ws(3'h0);
          beat_d = 3'h0;
          st_d = SMX_SETUP;
        end
      end
      SMX_SETUP: begin
        if (fall) begin
          wd_d = (ctrl_q[17:16] == 2'h2);
          moe_d = ctrl_q[1];
          st_d = SMX_WAIT;
        end
      end
      SMX_WAIT: begin
        // Later write beats re-arm the strobe on a rising edge, so every beat
        // gives the memory a strobe pulse of its own.
        if (rise && ctrl_q[1] && mwe_q) begin
          mwe_d = 1'b0;
        end
        // Wait states count down first; ready is sampled only once they are spent.
        if (fall) begin
          if (cnt_q != 3'h0) begin
            cnt_d = cnt_q - 3'h1;
          end else if (rdy_s) begin
            if (!ctrl_q[1]) begin
              rdat_d = rdata_s;
            end
            st_d = SMX_STROBE;
          end
        end
      end
      SMX_STROBE: begin
        if (rise) begin
          mwe_d = 1'b1;
          if (last_beat) begin
            st_d = SMX_DONE;
          end else begin
            // Next beat follows at once with no idle cycle.
            beat_d = beat_q + 3'h1;
            ma_d = ma_q + `SMX_ADDR_W'(4);
            cnt_d = beat_ws(beat_q + 3'h1);
            st_d = SMX_WAIT;
          end
        end
      end
      SMX_DONE: begin
        if (fall) begin
          // Address, qualifiers, direction and data keep their values.
          cs_d = '1;
          moe_d = 1'b1;
          oe_d = 1'b0;
          busy_d = 1'b0;
          st_d = SMX_IDLE;
        end
      end
      default: st_d = SMX_IDLE;
    endcase
    if (apb_wr && paddr == `SMX_REG_CTRL && pwdata[0] && !busy_q && start_ok) begin
      busy_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= SMX_IDLE;
      cnt_q <= 3'h0;
      beat_q <= 3'h0;
      cs_q <= '1;
      ma_q <= '0;
      mwe_q <= 1'b1;
      moe_q <= 1'b1;
      dir_q <= 1'b0;
      wd_q <= 1'b0;
      hw_q <= 1'b0;
      md_q <= '0;
      oe_q <= 1'b0;
      rdat_q <= '0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      beat_q <= beat_d;
      cs_q <= cs_d;
      ma_q <= ma_d;
      mwe_q <= mwe_d;
      moe_q <= moe_d;
      dir_q <= dir_d;
      wd_q <= wd_d;
      hw_q <= hw_d;
      md_q <= md_d;
      oe_q <= oe_d;
      rdat_q <= rdat_d;
      busy_q <= busy_d;
    end
  end

  // Register file. Writes while busy are ignored so the pins stay stable.
  always_comb begin
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    err_d = err_q;
    prdata_d = prdata_q;
    if (apb_wr && !busy_q) begin
      case (paddr)
        `SMX_REG_CTRL: begin
          // A bad combination is flagged and the start is dropped.
          ctrl_d = {pwdata[31:1], 1'b0};
          err_d = pwdata[1] & pwdata[3] & pwdata[2] & (pwdata[9:7] == 3'h0);
        end
        `SMX_REG_ADDR: addr_d = pwdata[`SMX_ADDR_W-1:0];
        `SMX_REG_WDATA: wdat_d = pwdata;
        default: ;
      endcase
    end
    if (apb_rd) begin
      case (paddr)
        `SMX_REG_CTRL: prdata_d = ctrl_q;
        `SMX_REG_ADDR: prdata_d = {4'h0, addr_q};
        `SMX_REG_WDATA: prdata_d = wdat_q;
        `SMX_REG_RDATA: prdata_d = rdat_q;
        `SMX_REG_STAT: prdata_d = {29'h0, bad_cfg, err_q, busy_q};
        default: prdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `SMX_CTRL_RST;
      addr_q <= '0;
      wdat_q <= '0;
      err_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      err_q <= err_d;
      prdata_q <= prdata_d;
    end
  end

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = prdata_q;
  assign chip_sel_n = cs_q;
  assign mem_addr = ma_q;
  assign mem_write_strobe_n = mwe_q;
  assign mem_output_strobe_n = moe_q;
  assign mem_write_dir = dir_q;
  assign mem_word = wd_q;
  assign mem_halfword = hw_q;
  assign mem_wdata = md_q;
  assign mem_wdata_oe = oe_q;

  a_strobe_excl: assert property (@(posedge pclk) disable iff (!presetn)
    !(!mwe_q && !moe_q)) else $error("both strobes active");
  a_wr_strobe_rise: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(mwe_q) |-> $past(rise)) else $error("write strobe off rising edge");
  a_oe_on_fall: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(moe_q) |-> $past(fall)) else $error("output strobe off falling edge");
  a_cs_release: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cs_q[0]) |-> $past(fall)) else $error("chip select release off falling edge");
  a_addr_launch: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(ma_q) |-> $past(rise)) else $error("address launched off rising edge");
  a_addr_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == SMX_IDLE && !busy_q) |=> $stable(ma_q) && $stable(md_q) && $stable(dir_q))
    else $error("address or data moved while idle");
  a_ready_stall: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == SMX_WAIT && fall && cnt_q == 3'h0 && !rdy_s) |=> st_q == SMX_WAIT)
    else $error("transfer done with ready low");
  a_burst_max: assert property (@(posedge pclk) disable iff (!presetn)
    beat_q < `SMX_BURST_MAX) else $error("burst beyond four beats");
  a_ws_count: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == SMX_WAIT && fall && cnt_q != 3'h0) |=> st_q == SMX_WAIT && cnt_q == $past(cnt_q) - 3'h1)
    else $error("wait state count skipped");
  a_bad_cfg: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(busy_q) |-> !bad_cfg) else $error("zero sequential write waits started");
endmodule

/* test/smx_mem_model.sv */
// Behavioural external memory that sits on the expansion port.
`timescale 1ns/1ns
module smx_mem_model (
  input wire logic bus_clock,
  input wire logic [5:0] chip_sel_n,
  input wire logic [27:0] mem_addr,
  input wire logic mem_write_strobe_n,
  input wire logic mem_output_strobe_n,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] stall_n,
  output logic ext_ready_in,
  output logic [31:0] mem_rdata,
  output logic [31:0] last_wdata,
  output int wr_count
);
  int falls;
  initial begin
    ext_ready_in = 1'b1;
    last_wdata = 32'h0;
    wr_count = 0;
    falls = 0;
  end
  // Ready moves well away from the clock edge, so the port must resynchronise it.
  always @(negedge bus_clock) begin
    falls = (&chip_sel_n) ? 0 : falls + 1;
    #17 ext_ready_in = (falls >= stall_n);
  end
  // Outside the output strobe the bus shows inverted junk, never the last word.
  always @* begin
    mem_rdata = mem_output_strobe_n ? ~{4'h5, mem_addr} : {4'h5, mem_addr};
  end
  always @(posedge mem_write_strobe_n) begin
    if (!(&chip_sel_n)) begin
      last_wdata = mem_wdata;
      wr_count++;
    end
  end
endmodule

/* test/tb.sv */
// Self-checking bench for the expansion port sequencer.
`timescale 1ns/1ns
`include "smx_params.svh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, bus_clock, ext_ready_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, last_wdata, mem_wdata, mem_rdata;
  logic pready, pslverr, mem_write_strobe_n, mem_output_strobe_n, mem_write_dir;
  logic mem_word, mem_halfword, mem_wdata_oe;
  logic [5:0] chip_sel_n;
  logic [27:0] mem_addr;
  logic [3:0] stall_n;
  int errors, checked, wr_count, cyc;
  time t0, d0, w0;
  smx_port DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bus_clock, .ext_ready_in, .chip_sel_n, .mem_addr,
    .mem_write_strobe_n, .mem_output_strobe_n, .mem_write_dir, .mem_word,
    .mem_halfword, .mem_wdata, .mem_wdata_oe, .mem_rdata);
  smx_mem_model mem (.bus_clock, .chip_sel_n, .mem_addr, .mem_write_strobe_n,
    .mem_output_strobe_n, .mem_wdata, .stall_n, .ext_ready_in, .mem_rdata,
    .last_wdata, .wr_count);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    bus_clock = 1'b0;
    #3;
    forever begin
      #62 bus_clock = 1'b1;
      #63 bus_clock = 1'b0;
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] ctrl(logic w, logic s, logic [2:0] ws, logic [2:0] sws,
      logic [2:0] bt);
    return 32'h1 | {w, 1'b0} | {s, 2'b0} | {w, 3'b0} | {ws, 4'b0} | {sws, 7'b0} | {bt, 10'b0};
  endfunction
  // Starts an access and polls the busy flag, recording how long it ran.
  task run(input logic [31:0] c);
    int n;
    n = 0;
    apb(1'b1, `SMX_REG_CTRL, c);
    do begin
      apb(1'b0, `SMX_REG_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 400);
    d0 = $time - t0;
    check(32'(n < 400), 32'h1);
  endtask
  // Durations start at the select edge, so the bus clock phase at start drops out.
  always @(negedge chip_sel_n[0]) t0 = $time;
  task final_report;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      final_report;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, stall_n} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SMX_REG_STAT, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    check(rd, 32'h0);
    check(32'(pslverr), 32'h0);
    $display("reset and unmapped test done");
    apb(1'b1, `SMX_REG_ADDR, 32'h100);
    run(ctrl(1'b0, 1'b0, 3'h2, 3'h0, 3'h0));
    w0 = d0;
    apb(1'b0, `SMX_REG_RDATA, 32'h0);
    check(rd, {4'h5, 28'h100});
    check(32'(mem_addr), 32'h100);
    check(32'(mem_write_dir), 32'h0);
    // Ready stays low for six falls: three periods past the programmed waits.
    stall_n <= 4'h6;
    run(ctrl(1'b0, 1'b0, 3'h2, 3'h0, 3'h0) | 32'h0001_0000);
    stall_n <= 4'h0;
    check(32'(d0 - w0 >= 250 && d0 - w0 <= 560), 32'h1);
    check(32'(mem_halfword), 32'h1);
    check(32'(mem_word), 32'h0);
    $display("single read and stall test done");
    apb(1'b1, `SMX_REG_ADDR, 32'h200);
    apb(1'b1, `SMX_REG_WDATA, 32'hcafe0001);
    run(ctrl(1'b1, 1'b0, 3'h1, 3'h0, 3'h0) | 32'h0002_0000);
    check(last_wdata, 32'hcafe0001);
    check(32'(mem_word), 32'h1);
    check(32'(mem_wdata_oe), 32'h0);
    check(mem_wdata, 32'hcafe0001);
    check(32'(mem_write_dir), 32'h1);
    check(32'(wr_count), 32'h1);
    apb(1'b1, `SMX_REG_ADDR, 32'h300);
    run(ctrl(1'b1, 1'b1, 3'h1, 3'h1, 3'h7));
    check(32'(wr_count), 32'h5);
    check(32'(mem_addr), 32'h30c);
    $display("write and burst write test done");
    for (int b = 2; b <= 4; b++) begin
      apb(1'b1, `SMX_REG_ADDR, 32'h400);
      run(ctrl(1'b0, 1'b1, 3'h0, 3'h0, 3'(b)));
      check(32'(mem_addr), 32'h400 + 32'(4 * (b - 1)));
      apb(1'b0, `SMX_REG_RDATA, 32'h0);
      check(rd, {4'h5, 28'h400 + 28'(4 * (b - 1))});
    end
    $display("burst read test done");
    run(ctrl(1'b1, 1'b1, 3'h2, 3'h0, 3'h2));
    check(32'(rd[1]), 32'h1);
    check(32'(wr_count), 32'h5);
    $display("refused config test done");
    final_report;
  end
endmodule
